// File: common/tic_pkg.sv
// Purpose: Shared constants and types for the terminal input conditioner
// Assumes: 100 MHz system clock, millisecond resolution for all terminal times
// Notes:   Register offsets are byte addresses on the plain register port

package tic_pkg;

	// ----------------------------------------------------------------
	// Geometry and timing
	// ----------------------------------------------------------------
	localparam int NUM_TERM       = 9;        // Eight general terminals plus high-speed
	localparam int NUM_DLY        = 5;        // Terminals with on/off delay registers
	localparam int HS_BIT         = 8;        // High-speed terminal bit position
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1000000;  // One millisecond time unit
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Terminals feeding the run command decoder
	localparam int FORWARD_BIT    = 0;
	localparam int REVERSE_BIT    = 1;
	localparam int ENA_BIT        = 2;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_POLARITY  = 8'h00;
	localparam logic [7:0] ADDR_FILTER    = 8'h04;
	localparam logic [7:0] ADDR_VIRT_SEL  = 8'h08;
	localparam logic [7:0] ADDR_MODE      = 8'h0C;
	localparam logic [7:0] ADDR_DLY_BASE  = 8'h10;  // On at base+8k, off at base+8k+4
	localparam logic [7:0] ADDR_VIRT_STATE = 8'h40;
	localparam logic [7:0] ADDR_STATUS    = 8'h44;

	localparam logic [8:0]  POLARITY_RST  = 9'h000;
	localparam logic [15:0] FILTER_RST    = 16'h000A; // 0.010 s in ms
	localparam logic [8:0]  VIRT_SEL_RST  = 9'h000;
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [15:0] DLY_RST       = 16'h0000;
	localparam logic [8:0]  VIRT_STATE_RST = 9'h000;

	// Status register fields
	localparam int ST_LVL_LSB     = 0;        // Accepted terminal levels, 9 bits
	localparam int ST_RUN_BIT     = 16;
	localparam int ST_DIR_BIT     = 17;

	// Terminal control modes
	localparam logic [1:0] MODE_TWO_WIRE_1   = 2'h0;
	localparam logic [1:0] MODE_TWO_WIRE_2   = 2'h1;
	localparam logic [1:0] MODE_THREE_WIRE_1 = 2'h2;

	typedef enum logic [1:0] {ST_STOP, ST_FORWARD, ST_REVERSE} tic_run_e;

endpackage

// File: src/tic_ms_tick.sv
// Purpose: Millisecond enable pulse for all terminal timers
// Assumes: Single system clock
// Notes:   Count is a parameter so simulation can shorten it

`timescale 1ns/10ps

module tic_ms_tick #(
	parameter int TICK_CYC = tic_pkg::TICK_CYCLES
) (
	input  wire logic clk_sys_i,  // System clock
	input  wire logic rst_i,      // Synchronous reset
	output logic      tick_o      // One-cycle pulse per ms
);

	logic [31:0] cnt;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cnt    <= 32'h0000_0000;
			tick_o <= 1'b0;
		end
		else if (cnt >= 32'(TICK_CYC - 1))
		begin
			cnt    <= 32'h0000_0000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt    <= cnt + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end

endmodule

// File: src/tic_qualify.sv
// Purpose: Accepts a level change once it has held for a programmed time
// Assumes: Times in ms ticks; zero accepts on the next clock
// Notes:   Used both as the sampling filter and the switch-on/off delay

`timescale 1ns/10ps

module tic_qualify (
	input  wire logic        clk_sys_i,  // System clock
	input  wire logic        rst_i,      // Synchronous reset
	input  wire logic        tick_i,     // ms enable
	input  wire logic        lvl_i,      // Raw level
	input  wire logic [15:0] rise_time_i, // Hold time for 0 to 1
	input  wire logic [15:0] fall_time_i, // Hold time for 1 to 0
	output logic             lvl_o       // Accepted level
);

	logic [15:0] cnt;
	logic [15:0] limit;

	assign limit = lvl_i ? rise_time_i : fall_time_i;

	// ----------------------------------------------------------------
	// Stability counter, restarted whenever input returns to output
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cnt   <= 16'h0000;
			lvl_o <= 1'b0;
		end
		else if (lvl_i == lvl_o)
			cnt <= 16'h0000;
		else if (cnt >= limit)
		begin
			lvl_o <= lvl_i;
			cnt   <= 16'h0000;
		end
		else if (tick_i)
			cnt <= cnt + 16'h0001;
	end

endmodule

// File: src/tic_top.sv
// Purpose: Conditions input terminals and decodes run and direction commands
// Assumes: Pins are asynchronous; terminal 1 forward, 2 reverse, 3 three-wire enable
// Notes:   Mode 3 is not decoded here and leaves the drive stopped

`timescale 1ns/10ps

// What this block does
// - A polarity bit of one inverts that terminal, making it active low.
// - A polarity bit of zero leaves the terminal uninverted; reset value is zero.
// - All nine terminals pass one common sampling filter, default 10 ms.
// - Virtual select bits 0-7 map to terminals 1-8, bit 8 to high-speed.
// - Two-bit control mode, reset to 0, selects the first two-wire scheme.
// - Two-wire 1: both off stops, forward alone runs forward, reverse alone reverse.
// - Two-wire 1: forward and reverse both on keeps the present state.
// - Mode 1: forward is run enable, reverse level selects direction.
// - Mode 2: with enable closed, forward rising edge starts in reverse's direction.
// - Mode 2: enable must stay closed while running; opening it stops the drive.
// - Mode 2: each reverse level change while running flips the direction.
module tic_top #(
	parameter int TICK_CYC = tic_pkg::TICK_CYCLES
) (
	input  wire logic        clk_sys_i,                   // System clock, 100 MHz
	input  wire logic        rst_i,                       // Synchronous reset
	input  wire logic [7:0]  general_input_terminals_i,   // Terminal pins 1-8
	input  wire logic        high_speed_input_terminal_i, // High-speed terminal pin
	input  wire logic [7:0]  addr_i,                      // Register byte address
	input  wire logic [31:0] wdata_i,                     // Write data
	input  wire logic        wr_i,                        // Write strobe
	input  wire logic        rd_i,                        // Read strobe
	output logic      [31:0] rdata_o,                     // Read data, cycle after rd_i
	output logic      [8:0]  term_level_o,                // Accepted terminal levels
	output logic             run_cmd_o,                   // Run command
	output logic             dir_reverse_o                // Direction, 1 = reverse
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [8:0]  input_polarity_mask;
	logic [15:0] input_filter_time;
	logic [8:0]  virtual_terminal_select;
	logic [1:0]  terminal_control_mode_sel;
	logic [8:0]  virt_state;
	logic [15:0] dly_on  [tic_pkg::NUM_DLY];
	logic [15:0] dly_off [tic_pkg::NUM_DLY];

	logic [8:0]  pin_raw;
	logic [8:0]  pin_meta;
	logic [8:0]  pin_sync;
	logic [8:0]  cond_lvl;
	logic [8:0]  filt_lvl;
	logic [8:0]  acc_lvl;
	logic        ms_tick;

	tic_pkg::tic_run_e run_st;
	tic_pkg::tic_run_e next_run_st;
	logic              forward_on;
	logic              reverse_on;
	logic              ena_on;
	logic              forward_prev;
	logic              reverse_prev;

	assign pin_raw = {high_speed_input_terminal_i, general_input_terminals_i};

	// ----------------------------------------------------------------
	// Pin synchroniser, only the second stage is read downstream
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pin_meta <= 9'h000;
			pin_sync <= 9'h000;
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			input_polarity_mask       <= tic_pkg::POLARITY_RST;
			input_filter_time         <= tic_pkg::FILTER_RST;
			virtual_terminal_select   <= tic_pkg::VIRT_SEL_RST;
			terminal_control_mode_sel <= tic_pkg::MODE_RST;
			virt_state                <= tic_pkg::VIRT_STATE_RST;
			for (int k = 0; k < tic_pkg::NUM_DLY; k++)
			begin
				dly_on[k]  <= tic_pkg::DLY_RST;
				dly_off[k] <= tic_pkg::DLY_RST;
			end
		end
		else if (wr_i)
		begin
			unique case (addr_i)
				tic_pkg::ADDR_POLARITY:   input_polarity_mask       <= wdata_i[8:0];
				tic_pkg::ADDR_FILTER:     input_filter_time         <= wdata_i[15:0];
				tic_pkg::ADDR_VIRT_SEL:   virtual_terminal_select   <= wdata_i[8:0];
				tic_pkg::ADDR_MODE:       terminal_control_mode_sel <= wdata_i[1:0];
				tic_pkg::ADDR_VIRT_STATE: virt_state                <= wdata_i[8:0];
				default:
				begin
					// Delay registers; other addresses are ignored
					for (int k = 0; k < tic_pkg::NUM_DLY; k++)
					begin
						if (addr_i == tic_pkg::ADDR_DLY_BASE + 8'(8 * k))
							dly_on[k] <= wdata_i[15:0];
						if (addr_i == tic_pkg::ADDR_DLY_BASE + 8'(8 * k + 4))
							dly_off[k] <= wdata_i[15:0];
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register reads, one cycle latency; unmapped reads return zero
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i)
		begin
			rdata_o <= 32'h0000_0000;
			unique case (addr_i)
				tic_pkg::ADDR_POLARITY:   rdata_o <= {23'h000000, input_polarity_mask};
				tic_pkg::ADDR_FILTER:     rdata_o <= {16'h0000, input_filter_time};
				tic_pkg::ADDR_VIRT_SEL:   rdata_o <= {23'h000000, virtual_terminal_select};
				tic_pkg::ADDR_MODE:       rdata_o <= {30'h00000000, terminal_control_mode_sel};
				tic_pkg::ADDR_VIRT_STATE: rdata_o <= {23'h000000, virt_state};
				tic_pkg::ADDR_STATUS:
				begin
					rdata_o[tic_pkg::ST_LVL_LSB +: 9] <= acc_lvl;
					rdata_o[tic_pkg::ST_RUN_BIT]      <= run_cmd_o;
					rdata_o[tic_pkg::ST_DIR_BIT]      <= dir_reverse_o;
				end
				default:
				begin
					for (int k = 0; k < tic_pkg::NUM_DLY; k++)
					begin
						if (addr_i == tic_pkg::ADDR_DLY_BASE + 8'(8 * k))
							rdata_o <= {16'h0000, dly_on[k]};
						if (addr_i == tic_pkg::ADDR_DLY_BASE + 8'(8 * k + 4))
							rdata_o <= {16'h0000, dly_off[k]};
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Virtual substitution and polarity, registered to cut the path
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			cond_lvl <= 9'h000;
		else
			cond_lvl <= ((virtual_terminal_select & virt_state)
				| (~virtual_terminal_select & pin_sync))
				^ input_polarity_mask;
	end

	tic_ms_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.tick_o    (ms_tick)
	);

	// ----------------------------------------------------------------
	// Per-terminal filter and, for terminals 1-5, on/off delay
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < tic_pkg::NUM_TERM; g++)
		begin : g_term
			// Common filter time for every terminal
			tic_qualify u_filt (
				.clk_sys_i   (clk_sys_i),
				.rst_i       (rst_i),
				.tick_i      (ms_tick),
				.lvl_i       (cond_lvl[g]),
				.rise_time_i (input_filter_time),
				.fall_time_i (input_filter_time),
				.lvl_o       (filt_lvl[g])
			);
			if (g < tic_pkg::NUM_DLY)
			begin : g_dly
				tic_qualify u_dly (
					.clk_sys_i   (clk_sys_i),
					.rst_i       (rst_i),
					.tick_i      (ms_tick),
					.lvl_i       (filt_lvl[g]),
					.rise_time_i (dly_on[g]),
					.fall_time_i (dly_off[g]),
					.lvl_o       (acc_lvl[g])
				);
			end
			else
			begin : g_nodly
				assign acc_lvl[g] = filt_lvl[g];
			end
		end
	endgenerate

	assign term_level_o = acc_lvl;
	assign forward_on   = acc_lvl[tic_pkg::FORWARD_BIT];
	assign reverse_on   = acc_lvl[tic_pkg::REVERSE_BIT];
	assign ena_on       = acc_lvl[tic_pkg::ENA_BIT];

	// ----------------------------------------------------------------
	// Run command decoder
	// ----------------------------------------------------------------
	always_comb
	begin
		next_run_st = run_st;
		unique case (terminal_control_mode_sel)
			tic_pkg::MODE_TWO_WIRE_1:
			begin
				if (!forward_on && !reverse_on)
					next_run_st = tic_pkg::ST_STOP;
				else if (forward_on && !reverse_on)
					next_run_st = tic_pkg::ST_FORWARD;
				else if (!forward_on && reverse_on)
					next_run_st = tic_pkg::ST_REVERSE;
				else
					next_run_st = run_st;
			end
			tic_pkg::MODE_TWO_WIRE_2:
			begin
				if (!forward_on)
					next_run_st = tic_pkg::ST_STOP;
				else
					next_run_st = reverse_on ? tic_pkg::ST_REVERSE : tic_pkg::ST_FORWARD;
			end
			tic_pkg::MODE_THREE_WIRE_1:
			begin
				if (!ena_on)
					next_run_st = tic_pkg::ST_STOP;
				else if (run_st == tic_pkg::ST_STOP)
				begin
					if (forward_on && !forward_prev)
						next_run_st = reverse_on ? tic_pkg::ST_REVERSE : tic_pkg::ST_FORWARD;
				end
				else if (reverse_on != reverse_prev)
					next_run_st = (run_st == tic_pkg::ST_FORWARD) ? tic_pkg::ST_REVERSE
						: tic_pkg::ST_FORWARD;
			end
			default:
				next_run_st = tic_pkg::ST_STOP;  // Mode 3 not decoded, stays safe
		endcase
	end

	// Run state and edge history; the history tracks in every mode so a
	// mode switch never sees a stale edge
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			run_st       <= tic_pkg::ST_STOP;
			forward_prev <= 1'b0;
			reverse_prev <= 1'b0;
		end
		else
		begin
			run_st       <= next_run_st;
			forward_prev <= forward_on;
			reverse_prev <= reverse_on;
		end
	end

	assign run_cmd_o     = (run_st != tic_pkg::ST_STOP);
	assign dir_reverse_o = (run_st == tic_pkg::ST_REVERSE);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_pol_invert: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(input_polarity_mask[0] && !virtual_terminal_select[0])
		|=> cond_lvl[0] == !$past(pin_sync[0]))
		else $error("Inverted terminal does not follow the inverted pin");

	chk_pol_plain: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(!input_polarity_mask[0] && !virtual_terminal_select[0])
		|=> cond_lvl[0] == $past(pin_sync[0]))
		else $error("Plain terminal does not follow the pin");

	chk_virt_subst: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		virtual_terminal_select[tic_pkg::HS_BIT]
		|=> cond_lvl[tic_pkg::HS_BIT] == ($past(virt_state[tic_pkg::HS_BIT])
			^ $past(input_polarity_mask[tic_pkg::HS_BIT])))
		else $error("Virtual terminal not taken from software state");

	chk_filter_accept: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		$changed(filt_lvl[8]) |-> filt_lvl[8] == $past(cond_lvl[8]))
		else $error("Filter accepted a level it was not given");

	chk_two_stop: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_TWO_WIRE_1 && !forward_on && !reverse_on)
		|=> !run_cmd_o)
		else $error("Two-wire stop not honoured");

	chk_two_hold: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_TWO_WIRE_1 && forward_on && reverse_on)
		|=> $stable(run_cmd_o) && $stable(dir_reverse_o))
		else $error("Two-wire hold changed the running state");

	chk_two_split: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_TWO_WIRE_2)
		|=> run_cmd_o == $past(forward_on)
			&& (!run_cmd_o || dir_reverse_o == $past(reverse_on)))
		else $error("Split two-wire enable or direction wrong");

	chk_three_start: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_THREE_WIRE_1 && ena_on
			&& !run_cmd_o && forward_on && !forward_prev)
		|=> run_cmd_o && dir_reverse_o == $past(reverse_on))
		else $error("Three-wire start missed or wrong direction");

	chk_three_drop: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_THREE_WIRE_1 && !ena_on)
		|=> !run_cmd_o)
		else $error("Three-wire open enable did not stop");

	chk_three_flip: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(terminal_control_mode_sel == tic_pkg::MODE_THREE_WIRE_1 && ena_on
			&& run_cmd_o && reverse_on != reverse_prev)
		|=> run_cmd_o && dir_reverse_o != $past(dir_reverse_o))
		else $error("Three-wire reverse change did not flip direction");

	chk_dly_zero: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(dly_on[0] == 16'h0000 && filt_lvl[0] && !acc_lvl[0]) |=> acc_lvl[0])
		else $error("Zero switch-on delay not immediate");

endmodule

// File: bench/tic_switch_model.sv
// Purpose: Model of the contacts wired to the input terminals
// Assumes: A contact drives a firm level at all times, open or closed
// Notes:   Optional chatter after each change, as a worn contact shows

`timescale 1ns/10ps

module tic_switch_model (
	input  wire logic       clk_sys_i, // System clock
	input  wire logic       rst_i,     // Synchronous reset
	input  wire logic [8:0] close_i,   // Wanted contact positions
	input  wire logic       bounce_i,  // Chatter before settling
	output logic      [7:0] gen_o,     // General terminal pins
	output logic            hs_o       // High-speed terminal pin
);
	logic [8:0] last;
	logic [8:0] diff;
	logic [2:0] chat;
	logic [8:0] pins;

	// ----------------------------------------------------------------
	// Contacts
	// ----------------------------------------------------------------
	// Only the bits that moved chatter, so other terminals stay clean
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			last <= 9'h000;
			diff <= 9'h000;
			chat <= 3'h0;
			pins <= 9'h000;
		end
		else
		begin
			last <= close_i;
			if (close_i != last && bounce_i)
			begin
				diff <= close_i ^ last;
				chat <= 3'h6;
			end
			else if (chat != 3'h0)
				chat <= chat - 3'h1;
			pins <= close_i ^ ((chat != 3'h0 && chat[0]) ? diff : 9'h000);
		end
	end

	assign gen_o = pins[7:0];
	assign hs_o  = pins[8];
endmodule

// File: bench/test_terminal_input_conditioner.sv
// Purpose: Self-checking bench for the terminal input conditioner
// Assumes: Time unit shortened to 10 clocks per ms
// Notes:   Pins come from the switch model; times are in ms units

`timescale 1ns/10ps

module test_terminal_input_conditioner;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [8:0]  term_level;
	logic        run_cmd;
	logic        dir_reverse;
	logic [7:0]  gen_pins;
	logic        hs_pin;
	logic [8:0]  close;
	logic        bounce;
	logic [31:0] rv;
	int          err_total;
	int          comparisons;

	// ----------------------------------------------------------------
	// Clock and instances
	// ----------------------------------------------------------------
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	tic_top #(.TICK_CYC(10)) tic_top_i (
		.clk_sys_i                   (clk_sys),
		.rst_i                       (rst),
		.general_input_terminals_i   (gen_pins),
		.high_speed_input_terminal_i (hs_pin),
		.addr_i                      (addr),
		.wdata_i                     (wdata),
		.wr_i                        (wr),
		.rd_i                        (rd),
		.rdata_o                     (rdata),
		.term_level_o                (term_level),
		.run_cmd_o                   (run_cmd),
		.dir_reverse_o               (dir_reverse)
	);

	tic_switch_model tic_switch_model_i (
		.clk_sys_i (clk_sys),
		.rst_i     (rst),
		.close_i   (close),
		.bounce_i  (bounce),
		.gen_o     (gen_pins),
		.hs_o      (hs_pin)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("Mismatches %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One-cycle strobes; the next call lets an edge pass first
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// Read data stand from the cycle after the strobe until the next read
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic put(input logic [8:0] v);
		@(posedge clk_sys);
		close <= v;
	endtask

	// Path latency is seven cycles with zero times; ten leaves margin
	task automatic settle;
		repeat (10) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_chk(input int n, input logic [8:0] exp);
		repeat (n) @(posedge clk_sys);
		#1;
		chk({23'h0, term_level}, {23'h0, exp});
	endtask

	// Drive forward, reverse and enable, then check the run outputs
	task automatic step(input logic [2:0] p, input logic r, input logic d);
		put({6'h00, p});
		settle();
		chk({30'h0, run_cmd, dir_reverse}, {30'h0, r, d});
	endtask

	function automatic logic [7:0] ra(input int i);
		return (i == 14) ? tic_pkg::ADDR_VIRT_STATE : 8'(i * 4);
	endfunction

	function automatic logic [31:0] rmask(input int i);
		if (i == 0 || i == 2 || i == 14)
			return 32'h000001FF;
		return (i == 3) ? 32'h00000003 : 32'h0000FFFF;
	endfunction

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// Tests need about 830 cycles; a hang is cut well beyond that
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		close = 9'h000;
		bounce = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values, then field widths through all-ones writes
		for (int i = 0; i < 15; i++)
		begin
			rd_reg(ra(i), rv);
			chk(rv, (i == 1) ? {16'h0, tic_pkg::FILTER_RST} : 32'h0);
			wr_reg(ra(i), 32'hFFFFFFFF);
			rd_reg(ra(i), rv);
			chk(rv, rmask(i));
		end
		for (int i = 0; i < 15; i++)
			wr_reg(ra(i), 32'h0);
		rd_reg(8'h80, rv);
		chk(rv, 32'h0);
		wr_reg(tic_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		settle();
		rd_reg(tic_pkg::ADDR_STATUS, rv);
		chk(rv, 32'h0);
		// Polarity walks every terminal with all contacts open
		for (int i = 0; i < 9; i++)
		begin
			wr_reg(tic_pkg::ADDR_POLARITY, 32'h1 << i);
			settle();
			chk({23'h0, term_level}, 32'h1 << i);
		end
		put(9'h1FF);
		wr_reg(tic_pkg::ADDR_POLARITY, 32'h000000F0);
		wait_chk(10, 9'h10F);
		// Virtual states replace selected pins, polarity still applies
		put(9'h0AA);
		wr_reg(tic_pkg::ADDR_VIRT_STATE, 32'h00000105);
		wr_reg(tic_pkg::ADDR_VIRT_SEL, 32'h0000010F);
		wr_reg(tic_pkg::ADDR_POLARITY, 32'h00000000);
		wait_chk(10, 9'h1A5);
		wr_reg(tic_pkg::ADDR_POLARITY, 32'h00000001);
		wait_chk(10, 9'h1A4);
		wr_reg(tic_pkg::ADDR_VIRT_SEL, 32'h0);
		wr_reg(tic_pkg::ADDR_POLARITY, 32'h0);
		put(9'h000);
		// Let every level fall before the filter lengthens, or terminal 8 starts high
		settle();
		// Filter of 3 ms: a 1 ms pulse is lost, a chattering hold is kept
		wr_reg(tic_pkg::ADDR_FILTER, 32'h3);
		put(9'h080);
		repeat (10) @(posedge clk_sys);
		put(9'h000);
		wait_chk(50, 9'h000);
		bounce <= 1'b1;
		put(9'h080);
		wait_chk(20, 9'h000);
		wait_chk(40, 9'h080);
		bounce <= 1'b0;
		put(9'h000);
		wr_reg(tic_pkg::ADDR_FILTER, 32'h0);
		// Terminal 1 with a 4 ms switch-on and 2 ms switch-off delay
		wr_reg(8'h10, 32'h4);
		wr_reg(8'h14, 32'h2);
		put(9'h001);
		wait_chk(30, 9'h000);
		wait_chk(30, 9'h001);
		put(9'h000);
		wait_chk(10, 9'h001);
		wait_chk(30, 9'h000);
		wr_reg(8'h10, 32'h0);
		wr_reg(8'h14, 32'h0);
		// First two-wire scheme, both on keeps the present state
		step(3'b000, 1'b0, 1'b0);
		step(3'b001, 1'b1, 1'b0);
		step(3'b011, 1'b1, 1'b0);
		step(3'b010, 1'b1, 1'b1);
		step(3'b011, 1'b1, 1'b1);
		step(3'b000, 1'b0, 1'b0);
		step(3'b011, 1'b0, 1'b0);
		step(3'b000, 1'b0, 1'b0);
		// Second two-wire scheme
		wr_reg(tic_pkg::ADDR_MODE, {30'h0, tic_pkg::MODE_TWO_WIRE_2});
		step(3'b001, 1'b1, 1'b0);
		step(3'b011, 1'b1, 1'b1);
		step(3'b010, 1'b0, 1'b0);
		step(3'b000, 1'b0, 1'b0);
		// Three-wire control; opening enable while running stops the drive
		wr_reg(tic_pkg::ADDR_MODE, {30'h0, tic_pkg::MODE_THREE_WIRE_1});
		step(3'b001, 1'b0, 1'b0);
		step(3'b000, 1'b0, 1'b0);
		step(3'b100, 1'b0, 1'b0);
		step(3'b110, 1'b0, 1'b0);
		step(3'b111, 1'b1, 1'b1);
		step(3'b110, 1'b1, 1'b1);
		rd_reg(tic_pkg::ADDR_STATUS, rv);
		chk(rv, 32'h00030006);
		step(3'b100, 1'b1, 1'b0);
		step(3'b110, 1'b1, 1'b1);
		step(3'b010, 1'b0, 1'b0);
		step(3'b100, 1'b0, 1'b0);
		step(3'b101, 1'b1, 1'b0);
		step(3'b001, 1'b0, 1'b0);
		// Fourth code is not decoded and must leave the drive stopped
		wr_reg(tic_pkg::ADDR_MODE, 32'h3);
		step(3'b101, 1'b0, 1'b0);
		wrap_up();
	end
endmodule
